//--- dpa_pkg.sv
// constants and carrier types of the dual pointer / aux control block
// assumes an 8-bit core with a one-cycle special-function register port
package dpa_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] AUX_CTRL_OFS = 8'ha2;
  localparam logic [7:0] SPI_CLK_OFS = 8'haf;
  localparam logic [7:0] PTR_LO_OFS = 8'h82;
  localparam logic [7:0] PTR_HI_OFS = 8'h83;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SEL_BIT = 0;
  localparam int ZERO_BIT = 2;
  localparam int FLAG_BIT = 3;
  localparam int BOOT_BIT = 5;
  localparam int FAST_BIT = 0;

  // ----------------------------------------------------------------
  // reset values, clock ratios and boot base
  // ----------------------------------------------------------------
  localparam logic [7:0] AUX_CTRL_RST = 8'h00;
  localparam logic [7:0] SPI_CLK_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [3:0] PERIODS_FAST = 4'h6;
  localparam logic [3:0] PERIODS_STD = 4'hc;
  localparam logic [15:0] BOOT_BASE = 16'hf800;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic load_lo;
    logic load_hi;
    logic inc;
    logic [7:0] data;
  } dpa_ptr_cmd_t;

  typedef enum logic [1:0] {
    DPA_RD_IDLE = 2'b00,
    DPA_RD_DONE = 2'b01
  } dpa_rd_state_t;

endpackage : dpa_pkg

//--- dpa_ptr_bank.sv
// two 16-bit external data pointers, only the selected one changes
// assumes i_sel is the select value that holds after this edge
`timescale 1ns/1ps
`default_nettype none
module dpa_ptr_bank
  import dpa_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // command and select
  input wire dpa_ptr_cmd_t i_cmd,
  input wire logic i_sel,
  // pointer of the selected slot, registered
  output logic [W-1:0] o_active
);

  logic [W-1:0] ptr_reg [2];
  logic [W-1:0] ptr_next [2];

  // ----------------------------------------------------------------
  // per-slot update, acting only on the selected slot
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_slot
    always_comb begin
      ptr_next[g] = ptr_reg[g];
      if (i_sel == 1'(g)) begin
        if (i_cmd.load_lo) begin
          ptr_next[g][7:0] = i_cmd.data;
        end else if (i_cmd.load_hi) begin
          ptr_next[g][W-1:8] = i_cmd.data;
        end else if (i_cmd.inc) begin
          ptr_next[g] = ptr_reg[g] + W'(1);
        end
      end
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        ptr_reg[g] <= PTR_RST;
      end else begin
        ptr_reg[g] <= ptr_next[g];
      end
    end
  end

  // active copy from next values so it never lags a select flip
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_active <= PTR_RST;
    end else begin
      o_active <= ptr_next[i_sel];
    end
  end

endmodule // dpa_ptr_bank
`default_nettype wire

//--- dpa_boot_dec.sv
// code address decoder for the boot memory window
// assumes the code address comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module dpa_boot_dec
  import dpa_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // window enable and code address
  input wire logic i_en,
  input wire logic [15:0] i_addr,
  // registered hit
  output logic o_hit
);

  // window runs from the base to the top of code space
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hit <= 1'b0;
    end else begin
      o_hit <= i_en && (i_addr >= BOOT_BASE);
    end
  end

endmodule // dpa_boot_dec
`default_nettype wire

//--- dpa_top.sv
// special-function logic: spi speed select, pointer select, aux flags
// assumes a core master on a one-cycle strobe port, same clock
`timescale 1ns/1ps
`default_nettype none
module dpa_top
  import dpa_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // register port
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // core side
  input wire logic I_CPU_DOUBLE_SPEED,
  input wire logic I_AUX_INC,
  input wire logic I_PTR_INC,
  input wire logic [15:0] I_CODE_ADDR,
  // status outputs
  output logic [15:0] O_EXT_ADDR,
  output logic O_POINTER_SELECT,
  output logic O_USER_FLAG,
  output logic O_BOOT_MAP_EN,
  output logic O_BOOT_HIT,
  output logic [3:0] O_SPI_PERIODS,
  output logic [3:0] O_CPU_PERIODS
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wr_aux;
  logic wr_spi;
  logic wr_lo;
  logic wr_hi;
  assign wr_aux = I_WR && hit(I_ADDR, AUX_CTRL_OFS);
  assign wr_spi = I_WR && hit(I_ADDR, SPI_CLK_OFS);
  assign wr_lo = I_WR && hit(I_ADDR, PTR_LO_OFS);
  assign wr_hi = I_WR && hit(I_ADDR, PTR_HI_OFS);

  // ----------------------------------------------------------------
  // aux control register
  // ----------------------------------------------------------------
  logic sel_reg;
  logic sel_next;
  logic flag_reg;
  logic flag_next;
  logic boot_reg;
  logic boot_next;
  logic [7:0] aux_view;
  logic [7:0] aux_sum;

  // reserved bits are not stored and read zero, bit2 is tied low
  always_comb begin
    aux_view = 8'h00;
    aux_view[SEL_BIT] = sel_reg;
    aux_view[ZERO_BIT] = 1'b0;
    aux_view[FLAG_BIT] = flag_reg;
    aux_view[BOOT_BIT] = boot_reg;
  end

  // read-modify-write increment; reserved bit1 reads zero and stops the carry
  assign aux_sum = aux_view + 8'h01;

  // explicit write beats a same-cycle increment request
  always_comb begin
    sel_next = sel_reg;
    flag_next = flag_reg;
    boot_next = boot_reg;
    if (wr_aux) begin
      sel_next = I_WDATA[SEL_BIT];
      flag_next = I_WDATA[FLAG_BIT];
      boot_next = I_WDATA[BOOT_BIT];
    end else if (I_AUX_INC) begin
      sel_next = aux_sum[SEL_BIT];
      flag_next = aux_sum[FLAG_BIT];
      boot_next = aux_sum[BOOT_BIT];
    end
  end

  // all aux fields start cleared
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sel_reg <= AUX_CTRL_RST[SEL_BIT];
      flag_reg <= AUX_CTRL_RST[FLAG_BIT];
      boot_reg <= AUX_CTRL_RST[BOOT_BIT];
    end else begin
      sel_reg <= sel_next;
      flag_reg <= flag_next;
      boot_reg <= boot_next;
    end
  end

  // ----------------------------------------------------------------
  // spi clock control register
  // ----------------------------------------------------------------
  logic fast_reg;

  // only bit0 is stored; upper bits are reserved
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      fast_reg <= SPI_CLK_RST[FAST_BIT];
    end else if (wr_spi) begin
      fast_reg <= I_WDATA[FAST_BIT];
    end
  end

  // ----------------------------------------------------------------
  // clock ratio outputs
  // ----------------------------------------------------------------
  // speed bit only counts while the core runs double speed
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_SPI_PERIODS <= PERIODS_STD;
      O_CPU_PERIODS <= PERIODS_STD;
    end else begin
      if (!I_CPU_DOUBLE_SPEED) begin
        O_SPI_PERIODS <= PERIODS_STD;
      end else if (fast_reg) begin
        O_SPI_PERIODS <= PERIODS_STD;
      end else begin
        O_SPI_PERIODS <= PERIODS_FAST;
      end
      O_CPU_PERIODS <= I_CPU_DOUBLE_SPEED ?
                       PERIODS_FAST : PERIODS_STD;
    end
  end

  // ----------------------------------------------------------------
  // data pointers
  // ----------------------------------------------------------------
  dpa_ptr_cmd_t ptr_cmd;
  logic [15:0] ptr_active;

  // byte writes win over a same-cycle core increment
  always_comb begin
    ptr_cmd.load_lo = wr_lo;
    ptr_cmd.load_hi = wr_hi;
    ptr_cmd.inc = I_PTR_INC && !wr_lo && !wr_hi;
    ptr_cmd.data = I_WDATA;
  end

  dpa_ptr_bank #(
    .W(16)
  ) u_bank (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_cmd(ptr_cmd),
    .i_sel(sel_next),
    .o_active(ptr_active)
  );

  // ----------------------------------------------------------------
  // boot window
  // ----------------------------------------------------------------
  logic boot_hit;

  dpa_boot_dec u_boot (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_en(boot_reg),
    .i_addr(I_CODE_ADDR),
    .o_hit(boot_hit)
  );

  // ----------------------------------------------------------------
  // read port and registered status
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;

  // unmapped offsets read zero; pointer bytes show the selected one
  always_comb begin
    rd_mux = 8'h00;
    if (hit(I_ADDR, AUX_CTRL_OFS)) begin
      rd_mux = aux_view;
    end else if (hit(I_ADDR, SPI_CLK_OFS)) begin
      rd_mux = {7'h00, fast_reg};
    end else if (hit(I_ADDR, PTR_LO_OFS)) begin
      rd_mux = ptr_active[7:0];
    end else if (hit(I_ADDR, PTR_HI_OFS)) begin
      rd_mux = ptr_active[15:8];
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      O_RDATA <= rd_mux;
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  // status mirrors of the aux fields
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_POINTER_SELECT <= 1'b0;
      O_USER_FLAG <= 1'b0;
      O_BOOT_MAP_EN <= 1'b0;
    end else begin
      O_POINTER_SELECT <= sel_next;
      O_USER_FLAG <= flag_next;
      O_BOOT_MAP_EN <= boot_next;
    end
  end

  // extra stage: external address trails the select by one edge
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_EXT_ADDR <= 16'h0000;
      O_BOOT_HIT <= 1'b0;
    end else begin
      O_EXT_ADDR <= ptr_active;
      O_BOOT_HIT <= boot_hit;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_NRST);

  // spi ratio is standard whenever double speed is off
  property p_spi_ignored;
    !I_CPU_DOUBLE_SPEED |=> O_SPI_PERIODS == 4'hc;
  endproperty
  a_spi_ignored: assert property (p_spi_ignored)
    else $error("spi ratio changed outside double speed");

  // in double speed the stored bit picks 6 or 12
  property p_spi_ratio;
    I_CPU_DOUBLE_SPEED |=>
      O_SPI_PERIODS == ($past(fast_reg) ? 4'hc : 4'h6);
  endproperty
  a_spi_ratio: assert property (p_spi_ratio)
    else $error("spi ratio wrong in double speed");

  // reserved spi bits read zero and bit0 follows last write
  property p_spi_read;
    I_RD && I_ADDR == 8'haf
      |=> O_RDATA[7:1] == 7'h00 && O_RDATA[0] == $past(fast_reg);
  endproperty
  a_spi_read: assert property (p_spi_read)
    else $error("spi register read wrong");

  // the unselected pointer holds through any pointer command
  property p_other_kept;
    !wr_aux && !I_AUX_INC
      |=> u_bank.ptr_reg[!sel_reg] == $past(u_bank.ptr_reg[!sel_reg]);
  endproperty
  a_other_kept: assert property (p_other_kept)
    else $error("unselected pointer changed");

  // external address follows the incrementing pointer
  property p_ptr_inc;
    I_PTR_INC && !I_WR && !I_AUX_INC ##1 1
      |=> O_EXT_ADDR == 16'($past(O_EXT_ADDR) + 16'h0001);
  endproperty
  a_ptr_inc: assert property (p_ptr_inc)
    else $error("selected pointer did not increment");

  // read of the aux register shows the select in bit0
  property p_sel_read;
    I_RD && I_ADDR == 8'ha2 |=> O_RDATA[0] == $past(O_POINTER_SELECT);
  endproperty
  a_sel_read: assert property (p_sel_read)
    else $error("select bit read wrong");

  // boot window hits two cycles after an address at the top
  property p_boot_hit;
    boot_reg && I_CODE_ADDR >= 16'hf800 |-> ##2 O_BOOT_HIT;
  endproperty
  a_boot_hit: assert property (p_boot_hit)
    else $error("boot window missed");

  // written flag value is kept
  property p_flag;
    wr_aux |=> O_USER_FLAG == $past(I_WDATA[3]);
  endproperty
  a_flag: assert property (p_flag)
    else $error("user flag not stored");

  // bit2 always reads zero, even just after writing ones
  property p_zero_bit;
    I_RD && I_ADDR == 8'ha2 |=> O_RDATA[2] == 1'b0;
  endproperty
  a_zero_bit: assert property (p_zero_bit)
    else $error("stuck bit read as one");

  // increment flips select and leaves the flag alone
  property p_aux_inc;
    I_AUX_INC && !wr_aux |=> O_POINTER_SELECT != $past(sel_reg)
      && O_USER_FLAG == $past(flag_reg);
  endproperty
  a_aux_inc: assert property (p_aux_inc)
    else $error("increment did not toggle select only");

  // cpu ratio follows double speed
  property p_cpu_ratio;
    I_CPU_DOUBLE_SPEED |=> O_CPU_PERIODS == 4'h6;
  endproperty
  a_cpu_ratio: assert property (p_cpu_ratio)
    else $error("cpu ratio wrong");

  // reserved aux bits never read as one
  property p_aux_rsvd;
    I_RD && I_ADDR == 8'ha2 |=> O_RDATA[7:6] == 2'b00
      && O_RDATA[4] == 1'b0 && O_RDATA[1] == 1'b0;
  endproperty
  a_aux_rsvd: assert property (p_aux_rsvd)
    else $error("reserved aux bit read as one");

  // main scenarios
  c_toggle_twice: cover property (I_AUX_INC ##1 I_AUX_INC);
  c_fast_spi: cover property (O_SPI_PERIODS == 4'h6);
  c_boot_hit: cover property (O_BOOT_HIT);
  c_second_ptr: cover property (O_POINTER_SELECT && I_PTR_INC);

endmodule // dpa_top
`default_nettype wire

//--- tb_dual_pointer_aux_ctrl.sv
// self-checking testbench of the dual pointer / aux control block
// assumes dpa_pkg and dpa_top compiled first, one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_dual_pointer_aux_ctrl;
  import dpa_pkg::*;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic I_CLK = 1'b0;
  logic I_NRST = 1'b0;
  logic [7:0] I_ADDR = 8'h00;
  logic [7:0] I_WDATA = 8'h00;
  logic I_WR = 1'b0;
  logic I_RD = 1'b0;
  logic I_CPU_DOUBLE_SPEED = 1'b0;
  logic I_AUX_INC = 1'b0;
  logic I_PTR_INC = 1'b0;
  logic [15:0] I_CODE_ADDR = 16'h0000;
  logic [7:0] O_RDATA;
  logic [15:0] O_EXT_ADDR;
  logic O_POINTER_SELECT;
  logic O_USER_FLAG;
  logic O_BOOT_MAP_EN;
  logic O_BOOT_HIT;
  logic [3:0] O_SPI_PERIODS;
  logic [3:0] O_CPU_PERIODS;
  int bad_count = 0;
  int num_checks = 0;

  dpa_top uut (
    .I_CLK(I_CLK), .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_CPU_DOUBLE_SPEED(I_CPU_DOUBLE_SPEED), .I_AUX_INC(I_AUX_INC),
    .I_PTR_INC(I_PTR_INC), .I_CODE_ADDR(I_CODE_ADDR),
    .O_EXT_ADDR(O_EXT_ADDR), .O_POINTER_SELECT(O_POINTER_SELECT),
    .O_USER_FLAG(O_USER_FLAG), .O_BOOT_MAP_EN(O_BOOT_MAP_EN),
    .O_BOOT_HIT(O_BOOT_HIT), .O_SPI_PERIODS(O_SPI_PERIODS),
    .O_CPU_PERIODS(O_CPU_PERIODS)
  );

  // ----------------------------------------------------------------
  // clock, verdict and watchdog
  // ----------------------------------------------------------------
  // 25 ns period
  initial begin
    forever #12.5 I_CLK = ~I_CLK;
  end

  task automatic report_and_stop();
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // tests need well under 300 cycles; 4000 leaves plenty of margin
  initial begin
    #(25 * 4000);
    bad_count++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // shared bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // the external address stage lags the pointer bank by one edge
  task automatic chk_ext(input logic [15:0] exp);
    @(posedge I_CLK);
    #1;
    chk(O_EXT_ADDR, exp);
  endtask

  // one-cycle write; its effect is visible just after the release edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_CLK);
    I_WR <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    chk({8'h00, O_RDATA}, {8'h00, exp});
  endtask

  task automatic aux_inc();
    @(posedge I_CLK);
    I_AUX_INC <= 1'b1;
    @(posedge I_CLK);
    I_AUX_INC <= 1'b0;
    #1;
  endtask

  task automatic ptr_inc();
    @(posedge I_CLK);
    I_PTR_INC <= 1'b1;
    @(posedge I_CLK);
    I_PTR_INC <= 1'b0;
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({15'h0000, O_POINTER_SELECT}, 16'h0000);
    chk(O_EXT_ADDR, PTR_RST);
    chk({12'h000, O_CPU_PERIODS}, {12'h000, PERIODS_STD});
    rd(AUX_CTRL_OFS, AUX_CTRL_RST);
    rd(SPI_CLK_OFS, SPI_CLK_RST);
  endtask

  // defined bits set, reserved left clear; stuck bit stays low
  task automatic t_aux_bits();
    wr(AUX_CTRL_OFS, 8'h2d);
    rd(AUX_CTRL_OFS, 8'h29);
    wr(AUX_CTRL_OFS, 8'h29);
    chk({15'h0000, O_POINTER_SELECT}, 16'h0001);
    chk({15'h0000, O_USER_FLAG}, 16'h0001);
    chk({15'h0000, O_BOOT_MAP_EN}, 16'h0001);
    wr(AUX_CTRL_OFS, 8'h08);
    rd(AUX_CTRL_OFS, 8'h08);
    aux_inc();
    chk({15'h0000, O_POINTER_SELECT}, 16'h0001);
    chk({15'h0000, O_USER_FLAG}, 16'h0001);
    aux_inc();
    rd(AUX_CTRL_OFS, 8'h08);
    wr(AUX_CTRL_OFS, 8'h00);
  endtask

  // speed bit counts only in double speed mode
  task automatic t_spi_ratio();
    logic [3:0] exp;
    for (int x = 0; x < 2; x++) begin
      for (int s = 0; s < 2; s++) begin
        @(posedge I_CLK);
        I_CPU_DOUBLE_SPEED <= x[0];
        wr(SPI_CLK_OFS, {7'h00, s[0]});
        repeat (2) @(posedge I_CLK);
        #1;
        exp = (x == 1 && s == 0) ? PERIODS_FAST : PERIODS_STD;
        chk({12'h000, O_SPI_PERIODS}, {12'h000, exp});
        exp = (x == 1) ? PERIODS_FAST : PERIODS_STD;
        chk({12'h000, O_CPU_PERIODS}, {12'h000, exp});
        rd(SPI_CLK_OFS, {7'h00, s[0]});
      end
    end
    wr(SPI_CLK_OFS, 8'hfe);
    rd(SPI_CLK_OFS, 8'h00);
    @(posedge I_CLK);
    I_CPU_DOUBLE_SPEED <= 1'b0;
  endtask

  // each pointer keeps its value while the other one is worked on
  task automatic t_pointers();
    wr(PTR_LO_OFS, 8'hff);
    wr(PTR_HI_OFS, 8'h12);
    chk_ext(16'h12ff);
    ptr_inc();
    chk_ext(16'h1300);
    aux_inc();
    chk_ext(16'h0000);
    wr(PTR_LO_OFS, 8'hff);
    wr(PTR_HI_OFS, 8'hff);
    ptr_inc();
    chk_ext(16'h0000);
    ptr_inc();
    rd(PTR_LO_OFS, 8'h01);
    aux_inc();
    chk_ext(16'h1300);
    rd(PTR_HI_OFS, 8'h13);
  endtask

  // boot window covers the top 2 KiB only while enabled
  task automatic t_boot();
    logic [15:0] addrs [3] = '{16'hf7ff, BOOT_BASE, 16'hffff};
    for (int e = 0; e < 2; e++) begin
      wr(AUX_CTRL_OFS, {2'b00, e[0], 5'h00});
      for (int i = 0; i < 3; i++) begin
        @(posedge I_CLK);
        I_CODE_ADDR <= addrs[i];
        repeat (3) @(posedge I_CLK);
        #1;
        chk({15'h0000, O_BOOT_HIT}, {15'h0000, e[0] && i > 0});
      end
    end
    wr(AUX_CTRL_OFS, 8'h00);
    chk({15'h0000, O_BOOT_MAP_EN}, 16'h0000);
  endtask

  // unmapped place reads zero; data stand for one cycle only
  task automatic t_unmapped();
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    @(posedge I_CLK);
    #1;
    chk({8'h00, O_RDATA}, 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge I_CLK);
    I_NRST <= 1'b1;
    #1;
    t_reset();
    t_aux_bits();
    t_spi_ratio();
    t_pointers();
    t_boot();
    t_unmapped();
    report_and_stop();
  end
endmodule // tb_dual_pointer_aux_ctrl
`default_nettype wire
